// ### pkg/swa_pkg.sv
// Constants, register offsets and carrier types for the single-wire authentication block.
// Assumes one 20 MHz clock shared with the single-wire decoder and the management-bus logic.
package swa_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned AUTH_BUSY_MS    = 22;
  localparam int unsigned AUTH_BUSY_CYCLES = AUTH_BUSY_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Single-wire register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_BUF_FIRST        = 8'h1B;
  localparam logic [7:0] OFS_BUF_LAST         = 8'h2E;
  localparam logic [7:0] OFS_AUTH_START       = 8'h2F;
  localparam logic [7:0] OFS_PACK_VOLT_HI     = 8'h40;
  localparam logic [7:0] OFS_PACK_VOLT_LO     = 8'h41;
  localparam logic [7:0] OFS_CELL4_HI         = 8'h42;
  localparam logic [7:0] OFS_CELL4_LO         = 8'h43;
  localparam logic [7:0] OFS_CELL3_HI         = 8'h44;
  localparam logic [7:0] OFS_CELL3_LO         = 8'h45;
  localparam logic [7:0] OFS_CELL2_HI         = 8'h46;
  localparam logic [7:0] OFS_CELL2_LO         = 8'h47;
  localparam logic [7:0] OFS_CELL1_HI         = 8'h48;
  localparam logic [7:0] OFS_CELL1_LO         = 8'h49;
  localparam logic [7:0] OFS_CYCLE_HI         = 8'h4A;
  localparam logic [7:0] OFS_CYCLE_LO         = 8'h4B;
  localparam logic [7:0] OFS_DATE_HI          = 8'h4C;
  localparam logic [7:0] OFS_DATE_LO          = 8'h4D;
  localparam logic [7:0] OFS_CURR_HI          = 8'h4E;
  localparam logic [7:0] OFS_CURR_LO          = 8'h4F;
  localparam logic [7:0] OFS_MEAN_HI          = 8'h50;
  localparam logic [7:0] OFS_MEAN_LO          = 8'h51;
  localparam logic [7:0] OFS_TEMP_HI          = 8'h52;
  localparam logic [7:0] OFS_TEMP_LO          = 8'h53;
  localparam logic [7:0] OFS_SERIAL_HI        = 8'h54;
  localparam logic [7:0] OFS_SERIAL_LO        = 8'h55;
  localparam logic [7:0] OFS_CHG_VOLT_HI      = 8'h56;
  localparam logic [7:0] OFS_CHG_VOLT_LO      = 8'h57;
  localparam logic [7:0] OFS_CHG_CURR_HI      = 8'h58;
  localparam logic [7:0] OFS_CHG_CURR_LO      = 8'h59;
  localparam logic [7:0] OFS_REL_CHARGE       = 8'h5A;
  localparam logic [7:0] OFS_ABS_CHARGE       = 8'h5B;
  localparam logic [7:0] OFS_ERR_HI           = 8'h5C;
  localparam logic [7:0] OFS_ERR_LO           = 8'h5D;

  // ----------------------------------------------------------------
  // Management-bus commands and key
  // ----------------------------------------------------------------
  localparam logic [7:0]   CMD_KEY_FIRST  = 8'h63;
  localparam logic [7:0]   CMD_KEY_LAST   = 8'h66;
  localparam logic [7:0]   CMD_CHALLENGE  = 8'h2F;
  localparam logic [127:0] KEY_DEFAULT    = 128'h0123456789ABCDEFFEDCBA9876543210;
  localparam logic [7:0]   READ_IDLE_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Hash constants
  // ----------------------------------------------------------------
  localparam logic [6:0]  SHA_LAST_ROUND = 7'h4F;
  localparam logic [31:0] SHA_PAD_WORD   = 32'h80000000;
  localparam logic [31:0] SHA_LEN_WORD   = 32'h00000120;
  localparam logic [31:0] SHA_H0 = 32'h67452301;
  localparam logic [31:0] SHA_H1 = 32'hEFCDAB89;
  localparam logic [31:0] SHA_H2 = 32'h98BADCFE;
  localparam logic [31:0] SHA_H3 = 32'h10325476;
  localparam logic [31:0] SHA_H4 = 32'hC3D2E1F0;
  localparam logic [31:0] SHA_K0 = 32'h5A827999;
  localparam logic [31:0] SHA_K1 = 32'h6ED9EBA1;
  localparam logic [31:0] SHA_K2 = 32'h8F1BBCDC;
  localparam logic [31:0] SHA_K3 = 32'hCA62C1D6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [15:0][31:0] swa_words_t;
  typedef logic [19:0][7:0]  swa_buf_t;

  typedef struct packed {
    logic [15:0] pack_voltage;
    logic [15:0] fourth_cell_voltage_cmd;
    logic [15:0] third_cell_voltage;
    logic [15:0] second_cell_voltage;
    logic [15:0] first_cell_voltage_cmd;
    logic [15:0] cycle_total;
    logic [15:0] build_date;
    logic [15:0] pack_current;
    logic [15:0] mean_current;
    logic [15:0] pack_temp;
    logic [15:0] serial_no;
    logic [15:0] charge_target_volt;
    logic [15:0] charge_target_curr;
    logic [7:0]  relative_charge;
    logic [7:0]  absolute_charge;
    logic [15:0] error_bound;
  } swa_meas_t;

  typedef enum logic [1:0] {
    SWA_IDLE   = 2'b00,
    SWA_HASH   = 2'b01,
    SWA_DIGEST = 2'b10,
    SWA_WAIT   = 2'b11
  } swa_state_t;

endpackage : swa_pkg

// ### verilog/swa_auth_regs.sv
// Single-wire register map with keyed SHA-1 challenge/response and measurement mirror.
// Assumes the single-wire bit decoder, the management-bus decoder and the gauging logic share clk_i.
//
// Behaviour
// - Twenty-byte buffer at 0x1B..0x2E, read/write.
// - Any write to 0x2F starts computation.
// - Ignore all single-wire traffic while computing.
// - Challenge byte 00 at lowest address.
// - Response overwrites buffer, little-endian.
// - Response is SHA-1 over key and challenge.
// - Key is four strings, unsealed access only.
// - Key writes hold until reset, which reloads the default; rejected when sealed.
// - Key strings stored little-endian.
// - Key defaults to the factory value.
// - Challenge also loadable via command 0x2F.
// - 0x40/0x41 mirror pack voltage.
// - Cell voltage pairs, cell 1 at 0x48.
// - Pairs 0x4A..0x59 mirror gauge values.
// - 0x5A/0x5B report relative/absolute charge.
// - 0x5C/0x5D report maximum error.
`timescale 1ns/1ps

module swa_auth_regs #(
  parameter int unsigned BUSY_CYCLES = swa_pkg::AUTH_BUSY_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic                   reg_rd_ack_o,
  output logic      [7:0]        reg_rdata_o,
  output logic                   busy_o,
  input  wire logic              sealed_i,
  input  wire logic              key_wr_i,
  input  wire logic              key_rd_i,
  input  wire logic [7:0]        key_cmd_i,
  input  wire logic [31:0]       key_wdata_i,
  output logic                   key_ack_o,
  output logic                   key_err_o,
  output logic      [31:0]       key_rdata_o,
  output logic      [127:0]      key_store_o,
  input  wire logic              chal_wr_i,
  input  wire logic [7:0]        chal_cmd_i,
  input  wire swa_pkg::swa_buf_t chal_data_i,
  input  wire swa_pkg::swa_meas_t meas_i
);
  import swa_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic swa_words_t load_block(input logic [127:0] key, input swa_buf_t chal);
    swa_words_t wv;
    wv = '0;
    for (int n = 0; n < 16; n++) begin
      wv[n/4][8*(3-(n%4)) +: 8] = key[8*n +: 8];
    end
    for (int j = 0; j < 20; j++) begin
      wv[(j+16)/4][8*(3-(j%4)) +: 8] = chal[j];
    end
    wv[9]  = SHA_PAD_WORD;
    wv[15] = SHA_LEN_WORD;
    return wv;
  endfunction : load_block

  function automatic logic [7:0] mirror_byte(input logic [7:0] a, input swa_meas_t m);
    logic [7:0] r;
    r = READ_IDLE_BYTE;
    unique case (a)
      OFS_PACK_VOLT_HI: r = m.pack_voltage[15:8];
      OFS_PACK_VOLT_LO: r = m.pack_voltage[7:0];
      OFS_CELL4_HI:     r = m.fourth_cell_voltage_cmd[15:8];
      OFS_CELL4_LO:     r = m.fourth_cell_voltage_cmd[7:0];
      OFS_CELL3_HI:     r = m.third_cell_voltage[15:8];
      OFS_CELL3_LO:     r = m.third_cell_voltage[7:0];
      OFS_CELL2_HI:     r = m.second_cell_voltage[15:8];
      OFS_CELL2_LO:     r = m.second_cell_voltage[7:0];
      OFS_CELL1_HI:     r = m.first_cell_voltage_cmd[15:8];
      OFS_CELL1_LO:     r = m.first_cell_voltage_cmd[7:0];
      OFS_CYCLE_HI:     r = m.cycle_total[15:8];
      OFS_CYCLE_LO:     r = m.cycle_total[7:0];
      OFS_DATE_HI:      r = m.build_date[15:8];
      OFS_DATE_LO:      r = m.build_date[7:0];
      OFS_CURR_HI:      r = m.pack_current[15:8];
      OFS_CURR_LO:      r = m.pack_current[7:0];
      OFS_MEAN_HI:      r = m.mean_current[15:8];
      OFS_MEAN_LO:      r = m.mean_current[7:0];
      OFS_TEMP_HI:      r = m.pack_temp[15:8];
      OFS_TEMP_LO:      r = m.pack_temp[7:0];
      OFS_SERIAL_HI:    r = m.serial_no[15:8];
      OFS_SERIAL_LO:    r = m.serial_no[7:0];
      OFS_CHG_VOLT_HI:  r = m.charge_target_volt[15:8];
      OFS_CHG_VOLT_LO:  r = m.charge_target_volt[7:0];
      OFS_CHG_CURR_HI:  r = m.charge_target_curr[15:8];
      OFS_CHG_CURR_LO:  r = m.charge_target_curr[7:0];
      OFS_REL_CHARGE:   r = m.relative_charge;
      OFS_ABS_CHARGE:   r = m.absolute_charge;
      OFS_ERR_HI:       r = m.error_bound[15:8];
      OFS_ERR_LO:       r = m.error_bound[7:0];
      default:          r = READ_IDLE_BYTE;
    endcase
    return r;
  endfunction : mirror_byte

  function automatic logic in_buffer(input logic [7:0] a);
    return (a >= OFS_BUF_FIRST) && (a <= OFS_BUF_LAST);
  endfunction : in_buffer

  // ----------------------------------------------------------------
  // Control, buffer and key state
  // ----------------------------------------------------------------
  swa_state_t   state_q, state_d;
  swa_buf_t     buf_q, buf_d;
  logic [127:0] key_q, key_d;
  logic [31:0]  cnt_q, cnt_d;
  logic         rd_ack_q, rd_ack_d;
  logic [7:0]   rdata_q, rdata_d;
  logic         kack_q, kack_d;
  logic         kerr_q, kerr_d;
  logic [31:0]  krdata_q, krdata_d;
  logic         start;
  logic         key_hit;
  logic [1:0]   key_idx;
  logic [4:0]   buf_idx;

  // Hash datapath state
  swa_words_t   w_q, w_d;
  logic [31:0]  a_q, b_q, c_q, d_q, e_q;
  logic [31:0]  a_d, b_d, c_d, d_d, e_d;
  logic [6:0]   rnd_q, rnd_d;
  logic [31:0]  f_val, k_val, temp;
  logic [159:0] digest;

  assign key_hit = (key_cmd_i >= CMD_KEY_FIRST) && (key_cmd_i <= CMD_KEY_LAST);
  assign key_idx = 2'(key_cmd_i - CMD_KEY_FIRST);
  assign buf_idx = 5'(reg_addr_i - OFS_BUF_FIRST);
  assign digest  = {a_q + SHA_H0, b_q + SHA_H1, c_q + SHA_H2, d_q + SHA_H3, e_q + SHA_H4};

  always_comb begin
    state_d  = state_q;
    buf_d    = buf_q;
    key_d    = key_q;
    cnt_d    = cnt_q;
    rd_ack_d = 1'b0;
    rdata_d  = rdata_q;
    kack_d   = 1'b0;
    kerr_d   = 1'b0;
    krdata_d = krdata_q;
    start    = 1'b0;
    unique case (state_q)
      SWA_IDLE: begin
        if (reg_wr_i) begin
          if (reg_addr_i == OFS_AUTH_START) begin
            start = 1'b1;
          end else if (in_buffer(reg_addr_i)) begin
            buf_d[buf_idx] = reg_wdata_i;
          end
        end else if (chal_wr_i && (chal_cmd_i == CMD_CHALLENGE)) begin
          buf_d = chal_data_i;
          start = 1'b1;
        end
        if (reg_rd_i && !reg_wr_i) begin
          rd_ack_d = 1'b1;
          rdata_d  = in_buffer(reg_addr_i) ? buf_q[buf_idx] : mirror_byte(reg_addr_i, meas_i);
        end
        if (start) begin
          cnt_d   = '0;
          state_d = SWA_HASH;
        end
      end
      SWA_HASH: begin
        cnt_d = cnt_q + 32'h1;
        if (rnd_q == SHA_LAST_ROUND) begin
          state_d = SWA_DIGEST;
        end
      end
      SWA_DIGEST: begin
        cnt_d   = cnt_q + 32'h1;
        buf_d   = digest;
        state_d = SWA_WAIT;
      end
      SWA_WAIT: begin
        // Bus stays deaf until the full busy time has passed
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= BUSY_CYCLES - 1) begin
          state_d = SWA_IDLE;
        end
      end
    endcase
    if (key_wr_i && key_hit) begin
      if (sealed_i) begin
        kerr_d = 1'b1;
      end else begin
        key_d[32*key_idx +: 32] = key_wdata_i;
        kack_d = 1'b1;
      end
    end else if (key_rd_i && key_hit) begin
      if (sealed_i) begin
        kerr_d   = 1'b1;
        krdata_d = '0;
      end else begin
        kack_d   = 1'b1;
        krdata_d = key_q[32*key_idx +: 32];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q  <= SWA_IDLE;
      buf_q    <= '0;
      key_q    <= KEY_DEFAULT;
      cnt_q    <= '0;
      rd_ack_q <= 1'b0;
      rdata_q  <= READ_IDLE_BYTE;
      kack_q   <= 1'b0;
      kerr_q   <= 1'b0;
      krdata_q <= '0;
    end else begin
      state_q  <= state_d;
      buf_q    <= buf_d;
      key_q    <= key_d;
      cnt_q    <= cnt_d;
      rd_ack_q <= rd_ack_d;
      rdata_q  <= rdata_d;
      kack_q   <= kack_d;
      kerr_q   <= kerr_d;
      krdata_q <= krdata_d;
    end
  end

  // ----------------------------------------------------------------
  // SHA-1 round engine, one round per clock
  // ----------------------------------------------------------------
  always_comb begin
    if (rnd_q < 7'd20) begin
      f_val = (b_q & c_q) | (~b_q & d_q);
      k_val = SHA_K0;
    end else if (rnd_q < 7'd40) begin
      f_val = b_q ^ c_q ^ d_q;
      k_val = SHA_K1;
    end else if (rnd_q < 7'd60) begin
      f_val = (b_q & c_q) | (b_q & d_q) | (c_q & d_q);
      k_val = SHA_K2;
    end else begin
      f_val = b_q ^ c_q ^ d_q;
      k_val = SHA_K3;
    end
    temp = {a_q[26:0], a_q[31:27]} + f_val + e_q + k_val + w_q[0];
    w_d = w_q;
    a_d = a_q;
    b_d = b_q;
    c_d = c_q;
    d_d = d_q;
    e_d = e_q;
    rnd_d = rnd_q;
    if (start) begin
      // Key bytes first, then challenge bytes, as one padded block
      w_d   = load_block(key_q, buf_d);
      a_d   = SHA_H0;
      b_d   = SHA_H1;
      c_d   = SHA_H2;
      d_d   = SHA_H3;
      e_d   = SHA_H4;
      rnd_d = '0;
    end else if (state_q == SWA_HASH) begin
      w_d   = {w_q[13] ^ w_q[8] ^ w_q[2] ^ w_q[0], w_q[15:1]};
      w_d[15] = {w_d[15][30:0], w_d[15][31]};
      a_d   = temp;
      b_d   = a_q;
      c_d   = {b_q[1:0], b_q[31:2]};
      d_d   = c_q;
      e_d   = d_q;
      rnd_d = rnd_q + 7'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_q   <= '0;
      a_q   <= '0;
      b_q   <= '0;
      c_q   <= '0;
      d_q   <= '0;
      e_q   <= '0;
      rnd_q <= '0;
    end else begin
      w_q   <= w_d;
      a_q   <= a_d;
      b_q   <= b_d;
      c_q   <= c_d;
      d_q   <= d_d;
      e_q   <= e_d;
      rnd_q <= rnd_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rd_ack_o = rd_ack_q;
  assign reg_rdata_o  = rdata_q;
  assign busy_o       = (state_q != SWA_IDLE);
  assign key_ack_o    = kack_q;
  assign key_err_o    = kerr_q;
  assign key_rdata_o  = krdata_q;
  assign key_store_o  = key_q;

endmodule : swa_auth_regs

// ### sim/swa_auth_regs_assertions.sv
// Concurrent checks on the ports of the authentication register block.
// Assumes one clock domain and the constants of swa_pkg.
`timescale 1ns/1ps
module swa_auth_regs_chk #(
  parameter int unsigned BUSY_CYCLES = 100
) (
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire logic               reg_wr_i,
  input wire logic               reg_rd_i,
  input wire logic [7:0]         reg_addr_i,
  input wire logic               reg_rd_ack_o,
  input wire logic [7:0]         reg_rdata_o,
  input wire logic               busy_o,
  input wire logic               sealed_i,
  input wire logic               key_wr_i,
  input wire logic               key_rd_i,
  input wire logic [7:0]         key_cmd_i,
  input wire logic [31:0]        key_wdata_i,
  input wire logic               key_ack_o,
  input wire logic               key_err_o,
  input wire logic [127:0]       key_store_o,
  input wire swa_pkg::swa_meas_t meas_i
);
  import swa_pkg::*;
  localparam int unsigned LO = BUSY_CYCLES - 1;
  localparam int unsigned HI = BUSY_CYCLES + 1;
  int unsigned busy_cnt_q;
  int unsigned busy_cnt_d;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Length of the current busy stretch
  always_comb busy_cnt_d = busy_o ? busy_cnt_q + 1 : 0;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_d;
  end

  sequence s_rd;
    reg_rd_i && !reg_wr_i && !busy_o;
  endsequence
  sequence s_start;
    reg_wr_i && reg_addr_i == OFS_AUTH_START && !busy_o;
  endsequence
  sequence s_key;
    (key_wr_i || key_rd_i) && key_cmd_i >= CMD_KEY_FIRST && key_cmd_i <= CMD_KEY_LAST;
  endsequence

  property p_rd_ack;
    s_rd |=> reg_rd_ack_o;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
  property p_busy_quiet;
    reg_rd_i && busy_o |=> !reg_rd_ack_o;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("read answered while busy");
  property p_ack_cause;
    reg_rd_ack_o |-> $past(reg_rd_i) && !$past(busy_o);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without a taken read");
  property p_start;
    s_start |=> busy_o [*8];
  endproperty
  a_start: assert property (p_start) else $error("start write did not raise busy");
  property p_busy_len;
    $fell(busy_o) |-> busy_cnt_q >= LO && busy_cnt_q <= HI;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy stretch of wrong length");
  property p_key_ok;
    s_key ##0 !sealed_i |=> key_ack_o && !key_err_o;
  endproperty
  a_key_ok: assert property (p_key_ok) else $error("unsealed key access not accepted");
  property p_key_ref;
    s_key ##0 sealed_i |=> key_err_o && !key_ack_o && $stable(key_store_o);
  endproperty
  a_key_ref: assert property (p_key_ref) else $error("sealed key access not refused");
  property p_key_wr;
    logic [1:0]  k;
    logic [31:0] d;
    (key_wr_i && !sealed_i && key_cmd_i >= CMD_KEY_FIRST && key_cmd_i <= CMD_KEY_LAST,
     k = key_cmd_i[1:0] - 2'h3, d = key_wdata_i) |=> key_store_o[32 * k +: 32] == d;
  endproperty
  a_key_wr: assert property (p_key_wr) else $error("key string stored in wrong place");
  property p_mirror;
    s_rd ##0 reg_addr_i == OFS_PACK_VOLT_HI |=> reg_rdata_o == $past(meas_i.pack_voltage[15:8]);
  endproperty
  a_mirror: assert property (p_mirror) else $error("pack voltage high byte wrong");
endmodule : swa_auth_regs_chk

bind swa_auth_regs swa_auth_regs_chk #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_rd_ack_o(reg_rd_ack_o), .reg_rdata_o(reg_rdata_o),
  .busy_o(busy_o), .sealed_i(sealed_i), .key_wr_i(key_wr_i), .key_rd_i(key_rd_i),
  .key_cmd_i(key_cmd_i), .key_wdata_i(key_wdata_i), .key_ack_o(key_ack_o),
  .key_err_o(key_err_o), .key_store_o(key_store_o), .meas_i(meas_i));

// ### sim/swa_host_model.sv
// Host controller model issuing single-wire register writes and reads.
// Assumes the block answers a taken read one cycle later.
`timescale 1ns/1ps
module swa_host_model (
  input  wire logic       clk_i,
  input  wire logic       reg_rd_ack_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_wr_o    = 1'b1;
    reg_addr_o  = a;
    reg_wdata_o = d;
    @(posedge clk_i);
    #1;
    reg_wr_o    = 1'b0;
    // Released lines carry the inverse, never the stale value
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_i);
    #1;
    reg_rd_o   = 1'b1;
    reg_addr_o = a;
    @(posedge clk_i);
    #1;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    ok         = reg_rd_ack_i;
    d          = reg_rdata_i;
  endtask : rd
endmodule : swa_host_model

// ### sim/tb_swa_auth_regs.sv
// Self-checking bench for the authentication register block.
// Assumes the host model drives the register strobes; busy time shortened.
`timescale 1ns/1ps
module tb_swa_auth_regs;
  import swa_pkg::*;
  localparam int unsigned BUSY = 100;
  logic         clk_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rd_ack_o, busy_o, sealed_i;
  logic         key_wr_i, key_rd_i, key_ack_o, key_err_o, chal_wr_i;
  logic [7:0]   reg_addr_i, reg_wdata_i, reg_rdata_o, key_cmd_i, chal_cmd_i;
  logic [31:0]  key_wdata_i, key_rdata_o, seed;
  logic [127:0] key_store_o, exp_key;
  swa_buf_t     chal_data_i, chal;
  swa_meas_t    meas_i;
  int           bad_count, check_count;

  swa_auth_regs #(.BUSY_CYCLES(BUSY)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_ack_o(reg_rd_ack_o),
    .reg_rdata_o(reg_rdata_o), .busy_o(busy_o), .sealed_i(sealed_i), .key_wr_i(key_wr_i),
    .key_rd_i(key_rd_i), .key_cmd_i(key_cmd_i), .key_wdata_i(key_wdata_i),
    .key_ack_o(key_ack_o), .key_err_o(key_err_o), .key_rdata_o(key_rdata_o),
    .key_store_o(key_store_o), .chal_wr_i(chal_wr_i), .chal_cmd_i(chal_cmd_i),
    .chal_data_i(chal_data_i), .meas_i(meas_i));
  swa_host_model u_host (
    .clk_i(clk_i), .reg_rd_ack_i(reg_rd_ack_o), .reg_rdata_i(reg_rdata_o),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // Hi byte of each mirrored pair sits first, matching the struct order
  function automatic logic [7:0] meas_byte(swa_meas_t m, logic [7:0] a);
    if (a < OFS_PACK_VOLT_HI || a > OFS_ERR_LO) return READ_IDLE_BYTE;
    return m[239 - 8 * (a - OFS_PACK_VOLT_HI) -: 8];
  endfunction : meas_byte

  function automatic swa_buf_t sha(logic [127:0] k, swa_buf_t c);
    logic [511:0] m;
    logic [31:0]  w [80];
    logic [31:0]  a, b, cc, d, e, f, t, kk;
    m = '0;
    for (int n = 0; n < 16; n++) m[511 - 8 * n -: 8] = k[8 * n +: 8];
    for (int j = 0; j < 20; j++) m[383 - 8 * j -: 8] = c[j];
    m[223:192] = SHA_PAD_WORD;
    m[31:0] = SHA_LEN_WORD;
    {a, b, cc, d, e} = {SHA_H0, SHA_H1, SHA_H2, SHA_H3, SHA_H4};
    for (int i = 0; i < 80; i++) begin
      if (i < 16) w[i] = m[511 - 32 * i -: 32];
      else begin
        t = w[i - 3] ^ w[i - 8] ^ w[i - 14] ^ w[i - 16];
        w[i] = {t[30:0], t[31]};
      end
      if (i < 20) {f, kk} = {(b & cc) | (~b & d), SHA_K0};
      else if (i < 40) {f, kk} = {b ^ cc ^ d, SHA_K1};
      else if (i < 60) {f, kk} = {(b & cc) | (b & d) | (cc & d), SHA_K2};
      else {f, kk} = {b ^ cc ^ d, SHA_K3};
      t = {a[26:0], a[31:27]} + f + e + kk + w[i];
      {a, b, cc, d, e} = {t, a, b[1:0], b[31:2], cc, d};
    end
    return {SHA_H0 + a, SHA_H1 + b, SHA_H2 + cc, SHA_H3 + d, SHA_H4 + e};
  endfunction : sha

  task automatic test_done();
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk(input logic [159:0] got, input logic [159:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.rd(a, d, ok);
    chk({ok, d}, {1'b1, exp});
  endtask : rd_chk

  task automatic key_op(input logic w, input logic [7:0] cmd, input logic [31:0] d);
    int k;
    k = int'(cmd - CMD_KEY_FIRST);
    @(posedge clk_i);
    #1;
    key_wr_i    = w;
    key_rd_i    = ~w;
    key_cmd_i   = cmd;
    key_wdata_i = d;
    @(posedge clk_i);
    #1;
    key_wr_i    = 1'b0;
    key_rd_i    = 1'b0;
    key_cmd_i   = ~cmd;
    key_wdata_i = ~d;
    if (w && !sealed_i) exp_key[32 * k +: 32] = d;
    chk({key_ack_o, key_err_o}, {~sealed_i, sealed_i});
    chk(key_store_o, exp_key);
    if (!w) chk(key_rdata_o, sealed_i ? 32'h0 : exp_key[32 * k +: 32]);
  endtask : key_op

  task automatic auth(input logic via_port);
    logic [7:0] d;
    logic       ok;
    int         n;
    swa_buf_t   resp;
    chal = {rnd(), rnd(), rnd(), rnd(), rnd()};
    if (via_port) begin
      // First beat carries a foreign command and must be ignored
      @(posedge clk_i);
      #1;
      chal_wr_i   = 1'b1;
      chal_cmd_i  = ~CMD_CHALLENGE;
      chal_data_i = ~chal;
      @(posedge clk_i);
      #1;
      chal_cmd_i  = CMD_CHALLENGE;
      chal_data_i = chal;
      chk(busy_o, 1'b0);
      @(posedge clk_i);
      #1;
      chal_wr_i   = 1'b0;
      chal_data_i = ~chal;
    end else begin
      for (int j = 0; j < 20; j++) u_host.wr(OFS_BUF_FIRST + 8'(j), chal[j]);
      u_host.wr(OFS_AUTH_START, 8'(rnd()));
    end
    chk(busy_o, 1'b1);
    u_host.rd(OFS_BUF_FIRST, d, ok);
    chk(ok, 1'b0);
    u_host.wr(OFS_AUTH_START, 8'h00);
    for (n = 0; n < 4 * BUSY && busy_o !== 1'b0; n++) begin
      @(posedge clk_i);
      #1;
    end
    if (n == 4 * BUSY) begin
      bad_count++;
      test_done();
    end
    // Wait done: response only read once busy is over
    resp = sha(exp_key, chal);
    for (int j = 0; j < 20; j++) rd_chk(OFS_BUF_FIRST + 8'(j), resp[j]);
  endtask : auth

  initial begin
    seed = 32'h00007F6D;
    bad_count = 0;
    check_count = 0;
    {rst_n_i, sealed_i, key_wr_i, key_rd_i, chal_wr_i} = 5'h00;
    key_cmd_i = 8'h00;
    key_wdata_i = 32'h0;
    chal_cmd_i = CMD_CHALLENGE;
    chal_data_i = '0;
    exp_key = KEY_DEFAULT;
    meas_i = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), 16'(rnd())};
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    chk({busy_o, key_store_o}, {1'b0, KEY_DEFAULT});
    for (int a = 8'h40; a <= 8'h5E; a++) rd_chk(8'(a), meas_byte(meas_i, 8'(a)));
    rd_chk(8'h30, READ_IDLE_BYTE);
    for (int j = 0; j < 20; j++) begin
      chal[j] = 8'(rnd());
      u_host.wr(OFS_BUF_FIRST + 8'(j), chal[j]);
    end
    u_host.wr(OFS_PACK_VOLT_HI, ~meas_i.pack_voltage[15:8]);
    for (int j = 0; j < 20; j++) rd_chk(OFS_BUF_FIRST + 8'(j), chal[j]);
    rd_chk(OFS_PACK_VOLT_HI, meas_i.pack_voltage[15:8]);
    auth(1'b0);
    for (int k = 0; k < 4; k++) key_op(1'b1, CMD_KEY_FIRST + 8'(k), rnd());
    key_op(1'b0, CMD_KEY_LAST, 32'h0);
    sealed_i = 1'b1;
    key_op(1'b1, 8'h64, rnd());
    key_op(1'b0, CMD_KEY_FIRST, 32'h0);
    auth(1'b1);
    // Reset in mid-computation reloads the default key
    u_host.wr(OFS_AUTH_START, 8'h00);
    rst_n_i = 1'b0;
    @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    exp_key = KEY_DEFAULT;
    chk({busy_o, key_store_o}, {1'b0, KEY_DEFAULT});
    rd_chk(OFS_BUF_FIRST, 8'h00);
    test_done();
  end
endmodule : tb_swa_auth_regs
